// File: hdl/hall_conv_pkg.sv
package hall_conv_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [5:0]  ANGLE_OUTPUT_ADDR            = 6'h13;
  localparam logic [5:0]  VECTOR_MAGNITUDE_OUTPUT_ADDR = 6'h14;
  localparam logic [15:0] RESULT_RESET                 = 16'h0000;

  // ---------------------------------------------------------------
  // Field layouts and encodings
  // ---------------------------------------------------------------
  localparam int          ANGLE_BITS      = 13;
  localparam int          ANGLE_FRAC_BITS = 4;
  localparam logic [12:0] ANGLE_FULL      = 13'h1680;  // 360 degrees in 1/16 steps
  localparam logic [2:0]  MODE_CONTINUOUS = 3'h2;
  localparam logic [2:0]  MODE_TRIG_A     = 3'h0;
  localparam logic [2:0]  MODE_TRIG_B     = 3'h1;
  localparam logic [2:0]  MODE_TRIG_C     = 3'h3;
  localparam logic [3:0]  CH_XZX          = 4'hd;
  localparam logic [3:0]  CH_YZY          = 4'he;
  localparam logic [1:0]  TEMPCO_NONE     = 2'h0;
  localparam logic [1:0]  PAIR_XY         = 2'h1;
  localparam logic [1:0]  PAIR_YZ         = 2'h2;
  localparam logic [1:0]  PAIR_XZ         = 2'h3;

  // ---------------------------------------------------------------
  // Timing in cycles
  // ---------------------------------------------------------------
  localparam logic [15:0] INIT_CYCLES_A   = 16'h0040;
  localparam logic [15:0] INIT_CYCLES_B   = 16'h0020;
  localparam logic [15:0] INIT_CYCLES_C   = 16'h0010;
  localparam logic [15:0] SLOT_CYCLES     = 16'h0020;
  localparam int          CORDIC_ITERS    = 16;

  typedef enum logic [1:0] {
    AXIS_X = 2'h0,
    AXIS_Y = 2'h1,
    AXIS_Z = 2'h2,
    AXIS_T = 2'h3
  } axis_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_INIT   = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_CORDIC = 3'h3,
    ST_DONE   = 3'h4
  } conv_state_t;

  typedef struct packed {
    logic [2:0] operating_mode;
    logic [3:0] axis_channel_select;
    logic [1:0] magnet_tempco_select;
    logic [1:0] angle_pair_select;
  } conv_cfg_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } axis_data_t;

endpackage : hall_conv_pkg

// File: hdl/hall_conversion_angle_results.sv
// Summary of operation
// - Angle reported 0 to 360 degrees in low 13 bits of result word.
// - Lowest four angle bits are sixteenths of a degree.
// - Read-only 16-bit magnitude of vector from the two angle axes.
// - Mode 010b converts continuously without any trigger.
// - Continuous mode overlaps integration of next sample with digitizing current.
// - Each digitized sample lands in its own axis result register.
// - Modes 00b, 001b and 011b perform triggered single-shot conversions.
// - Trigger from serial command, alert pin edge or chip select activity.
// - Triggered conversion waits a mode-dependent initialization delay first.
// - Channel select 1101b converts X, Z, X through one chain.
// - Pseudo-simultaneous slots evenly spaced; middle axis centred between repeats.
// - Symmetric Y, Z, Y ordering is also supported.
// - Tempco select resets to 00b, which disables magnet compensation.
// - Angle computed on chip by CORDIC from any two axes.
// - Angle axis pair select field chooses the two CORDIC inputs.
// - Result registers update only at end of conversion.
`timescale 1ns/1ps
`default_nettype none

module hall_conversion_angle_results #(
  parameter int W = 16
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire hall_conv_pkg::conv_cfg_t cfg,
  input  wire logic                     trig_cmd,
  input  wire logic                     alert_pin,
  input  wire logic                     cs_n_pin,
  input  wire logic                     sample_valid,
  input  wire logic [W-1:0]             sample_data,
  input  wire logic [5:0]               rd_addr,
  output logic                          sample_req,
  output hall_conv_pkg::axis_t          sample_axis,
  output logic                          integrate_next,
  output logic                          tempco_enable,
  output hall_conv_pkg::axis_data_t     axis_result,
  output logic [W-1:0]                  angle_output,
  output logic [W-1:0]                  vector_magnitude_output,
  output logic [W-1:0]                  rd_data,
  output logic                          conv_done
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] alert_sync;
  logic [2:0] cs_sync;
  logic [2:0] next_alert_sync;
  logic [2:0] next_cs_sync;
  logic       alert_lvl;
  logic       cs_lvl;
  logic       next_alert_lvl;
  logic       next_cs_lvl;

  always_comb begin
    next_alert_sync = {alert_sync[1:0], alert_pin};
    next_cs_sync    = {cs_sync[1:0], cs_n_pin};
    next_alert_lvl  = (alert_sync[2] == alert_sync[1]) ? alert_sync[2] : alert_lvl;
    next_cs_lvl     = (cs_sync[2] == cs_sync[1]) ? cs_sync[2] : cs_lvl;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      alert_sync <= 3'h7;
      cs_sync    <= 3'h7;
      alert_lvl  <= 1'b1;
      cs_lvl     <= 1'b1;
    end else begin
      alert_sync <= next_alert_sync;
      cs_sync    <= next_cs_sync;
      alert_lvl  <= next_alert_lvl;
      cs_lvl     <= next_cs_lvl;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  logic continuous;
  logic triggered;
  logic trigger;
  logic pseudo;
  logic [15:0] init_cycles;

  always_comb begin
    continuous = (cfg.operating_mode == hall_conv_pkg::MODE_CONTINUOUS);
    triggered  = (cfg.operating_mode == hall_conv_pkg::MODE_TRIG_A)
              || (cfg.operating_mode == hall_conv_pkg::MODE_TRIG_B)
              || (cfg.operating_mode == hall_conv_pkg::MODE_TRIG_C);
    trigger    = trig_cmd
              || (alert_lvl != next_alert_lvl)
              || (cs_lvl != next_cs_lvl);
    pseudo     = (cfg.axis_channel_select == hall_conv_pkg::CH_XZX)
              || (cfg.axis_channel_select == hall_conv_pkg::CH_YZY);
    case (cfg.operating_mode)
      hall_conv_pkg::MODE_TRIG_B: init_cycles = hall_conv_pkg::INIT_CYCLES_B;
      hall_conv_pkg::MODE_TRIG_C: init_cycles = hall_conv_pkg::INIT_CYCLES_C;
      default:                    init_cycles = hall_conv_pkg::INIT_CYCLES_A;
    endcase
    tempco_enable = (cfg.magnet_tempco_select != hall_conv_pkg::TEMPCO_NONE);
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  hall_conv_pkg::conv_state_t state;
  hall_conv_pkg::conv_state_t next_state;
  logic [15:0] timer;
  logic [15:0] next_timer;
  logic [1:0]  slot;
  logic [1:0]  next_slot;
  logic [1:0]  slot_last;
  hall_conv_pkg::axis_t cur_axis;
  hall_conv_pkg::axis_data_t data;
  hall_conv_pkg::axis_data_t next_data;
  logic        cordic_done;

  always_comb begin
    slot_last = pseudo ? 2'h2 : 2'h1;
    if (cfg.axis_channel_select == hall_conv_pkg::CH_XZX) begin
      cur_axis = (slot == 2'h1) ? hall_conv_pkg::AXIS_Z : hall_conv_pkg::AXIS_X;
    end else if (cfg.axis_channel_select == hall_conv_pkg::CH_YZY) begin
      cur_axis = (slot == 2'h1) ? hall_conv_pkg::AXIS_Z : hall_conv_pkg::AXIS_Y;
    end else begin
      cur_axis = (slot == 2'h0) ? hall_conv_pkg::AXIS_X : hall_conv_pkg::AXIS_Y;
    end
  end

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_slot  = slot;
    next_data  = data;
    case (state)
      hall_conv_pkg::ST_IDLE: begin
        next_slot = 2'h0;
        if (continuous) begin
          next_state = hall_conv_pkg::ST_SAMPLE;
          next_timer = hall_conv_pkg::SLOT_CYCLES;
        end else if (triggered && trigger) begin
          next_state = hall_conv_pkg::ST_INIT;
          next_timer = init_cycles;
        end
      end
      hall_conv_pkg::ST_INIT: begin
        if (timer <= 16'h0001) begin
          next_state = hall_conv_pkg::ST_SAMPLE;
          next_timer = hall_conv_pkg::SLOT_CYCLES;
        end else begin
          next_timer = timer - 16'h0001;
        end
      end
      hall_conv_pkg::ST_SAMPLE: begin
        if (timer > 16'h0001) begin
          next_timer = timer - 16'h0001;
        end
        if (sample_valid && timer <= 16'h0001) begin
          case (cur_axis)
            hall_conv_pkg::AXIS_X: next_data.x = sample_data;
            hall_conv_pkg::AXIS_Y: next_data.y = sample_data;
            hall_conv_pkg::AXIS_Z: next_data.z = sample_data;
            default:               next_data = data;
          endcase
          next_timer = hall_conv_pkg::SLOT_CYCLES;
          if (slot == slot_last) begin
            next_state = hall_conv_pkg::ST_CORDIC;
          end else begin
            next_slot = slot + 2'h1;
          end
        end
      end
      hall_conv_pkg::ST_CORDIC: begin
        if (cordic_done) begin
          next_state = hall_conv_pkg::ST_DONE;
        end
      end
      hall_conv_pkg::ST_DONE: begin
        next_slot  = 2'h0;
        next_timer = hall_conv_pkg::SLOT_CYCLES;
        next_state = continuous ? hall_conv_pkg::ST_SAMPLE : hall_conv_pkg::ST_IDLE;
      end
      default: next_state = hall_conv_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= hall_conv_pkg::ST_IDLE;
      timer <= 16'h0000;
      slot  <= 2'h0;
      data  <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      slot  <= next_slot;
      data  <= next_data;
    end
  end

  // ---------------------------------------------------------------
  // CORDIC vectoring
  // ---------------------------------------------------------------
  logic signed [W+1:0] cx;
  logic signed [W+1:0] cy;
  logic [19:0]         cz;
  logic [4:0]          iter;
  logic signed [W+1:0] next_cx;
  logic signed [W+1:0] next_cy;
  logic [19:0]         next_cz;
  logic [4:0]          next_iter;
  logic signed [W-1:0] in_a;
  logic signed [W-1:0] in_b;
  logic [17:0]         atan_tab [0:hall_conv_pkg::CORDIC_ITERS-1];

  // Arctangent steps in 1/1024 degree
  assign atan_tab[0]  = 18'h0b400;
  assign atan_tab[1]  = 18'h06a44;
  assign atan_tab[2]  = 18'h03825;
  assign atan_tab[3]  = 18'h01c80;
  assign atan_tab[4]  = 18'h00e4f;
  assign atan_tab[5]  = 18'h0072a;
  assign atan_tab[6]  = 18'h00395;
  assign atan_tab[7]  = 18'h001ca;
  assign atan_tab[8]  = 18'h000e5;
  assign atan_tab[9]  = 18'h00073;
  assign atan_tab[10] = 18'h00039;
  assign atan_tab[11] = 18'h0001d;
  assign atan_tab[12] = 18'h0000e;
  assign atan_tab[13] = 18'h00007;
  assign atan_tab[14] = 18'h00004;
  assign atan_tab[15] = 18'h00002;

  assign cordic_done = (iter == 5'(hall_conv_pkg::CORDIC_ITERS));

  always_comb begin
    case (cfg.angle_pair_select)
      hall_conv_pkg::PAIR_YZ: begin in_a = next_data.y; in_b = next_data.z; end
      hall_conv_pkg::PAIR_XZ: begin in_a = next_data.x; in_b = next_data.z; end
      default:                begin in_a = next_data.x; in_b = next_data.y; end
    endcase
  end

  always_comb begin
    next_cx   = cx;
    next_cy   = cy;
    next_cz   = cz;
    next_iter = iter;
    if (state != hall_conv_pkg::ST_CORDIC) begin
      // Pre-rotate into right half plane, angle seeded 0 or 180 deg
      next_iter = 5'h0;
      next_cx   = (in_a < 0) ? -(W+2)'(in_a) : (W+2)'(in_a);
      next_cy   = (in_a < 0) ? -(W+2)'(in_b) : (W+2)'(in_b);
      next_cz   = (in_a < 0) ? 20'h2d000 : 20'h00000;
    end else if (!cordic_done) begin
      next_iter = iter + 5'h1;
      if (cy < 0) begin
        next_cx = cx - (cy >>> iter);
        next_cy = cy + (cx >>> iter);
        next_cz = cz - 20'(atan_tab[iter[3:0]]);
      end else begin
        next_cx = cx + (cy >>> iter);
        next_cy = cy - (cx >>> iter);
        next_cz = cz + 20'(atan_tab[iter[3:0]]);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cx   <= '0;
      cy   <= '0;
      cz   <= '0;
      iter <= 5'h0;
    end else begin
      cx   <= next_cx;
      cy   <= next_cy;
      cz   <= next_cz;
      iter <= next_iter;
    end
  end

  // ---------------------------------------------------------------
  // Result registers
  // ---------------------------------------------------------------
  logic [19:0]  ang64;
  logic [12:0]  ang16;
  logic [W+17:0] mag_scaled;
  logic [W-1:0] next_angle;
  logic [W-1:0] next_mag;
  hall_conv_pkg::axis_data_t next_axis_result;

  always_comb begin
    ang64 = (cz[19] ? cz + 20'h5a000 : cz);  // wrap negative into 0..360
    ang16 = 13'(ang64 >> 6);
    if (ang16 >= hall_conv_pkg::ANGLE_FULL) begin
      ang16 = ang16 - hall_conv_pkg::ANGLE_FULL;
    end
    // Remove CORDIC gain (about 0.6073 = 0x26dd / 2^14)
    mag_scaled       = (W+18)'(cx) * (W+18)'(16'h26dd);
    next_angle       = angle_output;
    next_mag         = vector_magnitude_output;
    next_axis_result = axis_result;
    if (state == hall_conv_pkg::ST_DONE) begin
      next_angle       = {3'h0, ang16};
      next_mag         = mag_scaled[W+13:14];
      next_axis_result = data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      angle_output            <= hall_conv_pkg::RESULT_RESET;
      vector_magnitude_output <= hall_conv_pkg::RESULT_RESET;
      axis_result             <= '0;
    end else begin
      angle_output            <= next_angle;
      vector_magnitude_output <= next_mag;
      axis_result             <= next_axis_result;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    sample_req     = (state == hall_conv_pkg::ST_SAMPLE);
    sample_axis    = cur_axis;
    integrate_next = continuous && (state != hall_conv_pkg::ST_IDLE);
    conv_done      = (state == hall_conv_pkg::ST_DONE);
    case (rd_addr)
      hall_conv_pkg::ANGLE_OUTPUT_ADDR:            rd_data = angle_output;
      hall_conv_pkg::VECTOR_MAGNITUDE_OUTPUT_ADDR: rd_data = vector_magnitude_output;
      default:                                     rd_data = '0;
    endcase
  end

endmodule : hall_conversion_angle_results

`default_nettype wire

// File: tb/hall_adc_model.sv
`timescale 1ns/1ps
`default_nettype none

module hall_adc_model (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 slow,
  input  wire logic                 sample_req,
  input  wire hall_conv_pkg::axis_t sample_axis,
  output logic                      sample_valid,
  output logic [15:0]               sample_data
);
  logic [11:0]          hop;
  logic [5:0]           wait_cnt;
  logic                 req_d;
  hall_conv_pkg::axis_t last_axis;

  // ---------------------------------------------------------------
  // Converter answers, tagged by axis and hop count
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    req_d     <= sample_req;
    last_axis <= sample_axis;
    if (rst || !sample_req) begin
      hop      <= 12'h000;
      wait_cnt <= 6'h00;
    end else if (req_d && sample_axis != last_axis) begin
      hop      <= hop + 12'h001;
      wait_cnt <= 6'h00;
    end else if (wait_cnt != 6'h3f) begin
      wait_cnt <= wait_cnt + 6'h01;
    end
    sample_valid <= sample_req && (!slow || wait_cnt > 6'h27);
    // Idle data toggles so a stale value is never mistaken for a sample
    sample_data  <= rst ? 16'h0000 : sample_req ? {sample_axis, 2'h0, hop} : ~sample_data;
  end
endmodule : hall_adc_model

`default_nettype wire

// File: tb/hall_conv_sva.sv
`timescale 1ns/1ps
`default_nettype none

module hall_conv_sva #(
  parameter int W = 16
) (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire hall_conv_pkg::conv_cfg_t  cfg,
  input wire logic [5:0]                rd_addr,
  input wire logic                      sample_req,
  input wire hall_conv_pkg::axis_t      sample_axis,
  input wire logic                      integrate_next,
  input wire logic                      tempco_enable,
  input wire hall_conv_pkg::axis_data_t axis_result,
  input wire logic [W-1:0]              angle_output,
  input wire logic [W-1:0]              vector_magnitude_output,
  input wire logic [W-1:0]              rd_data,
  input wire logic                      conv_done
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_angle_span:
    assert property (angle_output[15:13] == 3'h0
                     && angle_output[12:0] <= hall_conv_pkg::ANGLE_FULL)
    else $error("angle out of range");
  a_angle_read:
    assert property (rd_addr == hall_conv_pkg::ANGLE_OUTPUT_ADDR |-> rd_data == angle_output)
    else $error("angle read mismatch");
  a_mag_read:
    assert property (rd_addr == hall_conv_pkg::VECTOR_MAGNITUDE_OUTPUT_ADDR
                     |-> rd_data == vector_magnitude_output)
    else $error("magnitude read mismatch");
  a_unmapped_zero:
    assert property (rd_addr != hall_conv_pkg::ANGLE_OUTPUT_ADDR
                     && rd_addr != hall_conv_pkg::VECTOR_MAGNITUDE_OUTPUT_ADDR |-> rd_data == '0)
    else $error("unmapped read not zero");
  a_pipe_flag:
    assert property (cfg.operating_mode == hall_conv_pkg::MODE_CONTINUOUS && sample_req
                     |-> integrate_next)
    else $error("pipelining flag missing");
  a_tempco_map:
    assert property ($stable(cfg.magnet_tempco_select)
                     |-> tempco_enable == (cfg.magnet_tempco_select != hall_conv_pkg::TEMPCO_NONE))
    else $error("tempco enable wrong");
  a_done_pulse:
    assert property (conv_done |=> !conv_done)
    else $error("done longer than one cycle");
  a_results_hold:
    assert property (!$past(conv_done) && !$past(rst) |-> $stable(angle_output)
                     && $stable(vector_magnitude_output) && $stable(axis_result))
    else $error("result changed outside conversion end");
  a_cordic_bound:
    assert property ($fell(sample_req) |-> ##[1:24] conv_done)
    else $error("angle engine too slow");
  a_req_axis:
    assert property (sample_req |-> sample_axis != hall_conv_pkg::AXIS_T)
    else $error("bad sample axis");
  a_yzy_start:
    assert property ($rose(sample_req) && cfg.axis_channel_select == hall_conv_pkg::CH_YZY
                     |-> sample_axis == hall_conv_pkg::AXIS_Y)
    else $error("yzy not starting on y");

  c_done: cover property (conv_done);
  c_cont: cover property (cfg.operating_mode == hall_conv_pkg::MODE_CONTINUOUS && conv_done);
  c_xzx:  cover property (cfg.axis_channel_select == hall_conv_pkg::CH_XZX && conv_done);
endmodule : hall_conv_sva

bind hall_conversion_angle_results hall_conv_sva #(.W(W)) chk (
  .mclk, .rst, .cfg, .rd_addr, .sample_req, .sample_axis, .integrate_next,
  .tempco_enable, .axis_result, .angle_output, .vector_magnitude_output, .rd_data,
  .conv_done
);

`default_nettype wire

// File: tb/hall_conversion_angle_results_tb.sv
`timescale 1ns/1ps
`default_nettype none

module hall_conversion_angle_results_tb;
  logic                       mclk = 1'b0;
  logic                       rst;
  hall_conv_pkg::conv_cfg_t   cfg;
  logic                       trig_cmd;
  logic                       alert_pin;
  logic                       cs_n_pin;
  logic                       slow;
  logic                       sample_valid;
  logic [15:0]                sample_data;
  logic [5:0]                 rd_addr;
  logic                       sample_req;
  hall_conv_pkg::axis_t       sample_axis;
  logic                       integrate_next;
  logic                       tempco_enable;
  hall_conv_pkg::axis_data_t  axis_result;
  logic [15:0]                angle_output;
  logic [15:0]                vector_magnitude_output;
  logic [15:0]                rd_data;
  logic                       conv_done;
  int                         err_count = 0;
  int                         checks_done = 0;

  always #4 mclk = ~mclk;

  hall_conversion_angle_results uut (
    .mclk(mclk), .rst(rst), .cfg(cfg), .trig_cmd(trig_cmd), .alert_pin(alert_pin),
    .cs_n_pin(cs_n_pin), .sample_valid(sample_valid), .sample_data(sample_data),
    .rd_addr(rd_addr), .sample_req(sample_req), .sample_axis(sample_axis),
    .integrate_next(integrate_next), .tempco_enable(tempco_enable),
    .axis_result(axis_result), .angle_output(angle_output),
    .vector_magnitude_output(vector_magnitude_output), .rd_data(rd_data),
    .conv_done(conv_done)
  );

  hall_adc_model adc (
    .mclk(mclk), .rst(rst), .slow(slow), .sample_req(sample_req),
    .sample_axis(sample_axis), .sample_valid(sample_valid), .sample_data(sample_data)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge mclk);
    rd_addr <= a;
    #1 v = rd_data;
  endtask : rd

  task automatic fire;
    @(posedge mclk);
    trig_cmd <= 1'b1;
    @(posedge mclk);
    trig_cmd <= 1'b0;
  endtask : fire

  task automatic wait_req(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (sample_req !== 1'b1 && n < 300);
  endtask : wait_req

  task automatic wait_done(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (conv_done !== 1'b1 && n < lim);
    chk("done_seen", 16'h0001, {15'h0, conv_done});
    @(posedge mclk);
    #1;
  endtask : wait_done

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] v;
    rd(hall_conv_pkg::ANGLE_OUTPUT_ADDR, v);
    chk("angle_rst", 16'h0000, v);
    rd(hall_conv_pkg::VECTOR_MAGNITUDE_OUTPUT_ADDR, v);
    chk("mag_rst", 16'h0000, v);
    rd(6'h15, v);
    chk("unmapped", 16'h0000, v);
    chk("tempco_off", 16'h0000, {15'h0, tempco_enable});
    @(posedge mclk);
    cfg.magnet_tempco_select <= 2'h1;
    repeat (2) @(posedge mclk);
    #1 chk("tempco_on", 16'h0001, {15'h0, tempco_enable});
    @(posedge mclk);
    cfg.magnet_tempco_select <= 2'h0;
  endtask : t_reset

  task automatic t_modes;
    logic [2:0]  m [3];
    logic [15:0] d [3];
    logic [15:0] v;
    int          n;
    m = '{hall_conv_pkg::MODE_TRIG_A, hall_conv_pkg::MODE_TRIG_B, hall_conv_pkg::MODE_TRIG_C};
    d = '{hall_conv_pkg::INIT_CYCLES_A, hall_conv_pkg::INIT_CYCLES_B,
          hall_conv_pkg::INIT_CYCLES_C};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      cfg.operating_mode <= m[i];
      fire();
      wait_req(n);
      chk("init_wait", d[i], 16'(n));
      wait_done(300);
      chk("x_res", 16'h0000, axis_result.x);
      chk("y_res", 16'h4001, axis_result.y);
      rd(hall_conv_pkg::ANGLE_OUTPUT_ADDR, v);
      chk("angle_90", 16'h0001, {15'h0, v > 16'h059a && v < 16'h05a6});
      rd(hall_conv_pkg::VECTOR_MAGNITUDE_OUTPUT_ADDR, v);
      chk("mag_len", 16'h0001, {15'h0, v > 16'h3ff0 && v < 16'h4010});
    end
  endtask : t_modes

  task automatic t_pins;
    @(posedge mclk);
    alert_pin <= 1'b0;
    wait_done(400);
    @(posedge mclk);
    cs_n_pin <= 1'b0;
    wait_done(400);
    @(posedge mclk);
    cs_n_pin <= 1'b1;
    wait_done(400);
  endtask : t_pins

  task automatic t_pseudo(input logic [3:0] ch, input logic [1:0] outer,
                          input logic [15:0] o_exp, input logic [1:0] pair,
                          input logic [15:0] a_exp);
    int         t [3];
    int         n;
    int         k;
    logic [1:0] seq [2];
    logic [1:0] pa;
    logic [15:0] v;
    t = '{0, 0, 0};
    seq = '{2'h3, 2'h3};
    k = 0;
    @(posedge mclk);
    cfg.axis_channel_select <= ch;
    cfg.angle_pair_select <= pair;
    fire();
    wait_req(n);
    pa = sample_axis;
    chk("first_axis", {14'h0, outer}, {14'h0, pa});
    while (k < 3 && n < 600) begin
      @(posedge mclk);
      #1 n++;
      if (sample_req !== 1'b1) begin
        t[2] = n;
        k = 3;
      end else if (sample_axis !== pa && k < 2) begin
        pa = sample_axis;
        t[k] = n;
        seq[k] = pa;
        k++;
      end
    end
    chk("mid_axis", {14'h0, hall_conv_pkg::AXIS_Z}, {14'h0, seq[0]});
    chk("end_axis", {14'h0, outer}, {14'h0, seq[1]});
    chk("gap_a", hall_conv_pkg::SLOT_CYCLES, 16'(t[1] - t[0]));
    chk("gap_b", 16'(t[1] - t[0]), 16'(t[2] - t[1]));
    wait_done(100);
    chk("outer_res", o_exp, outer[0] ? axis_result.y : axis_result.x);
    chk("mid_res", 16'h8001, axis_result.z);
    rd(hall_conv_pkg::ANGLE_OUTPUT_ADDR, v);
    chk("pair_angle", 16'h0001, {15'h0, v + 16'h0006 > a_exp && v < a_exp + 16'h0006});
  endtask : t_pseudo

  task automatic t_hold;
    logic [15:0] a0;
    logic [15:0] a1;
    int          n;
    rd(hall_conv_pkg::ANGLE_OUTPUT_ADDR, a0);
    @(posedge mclk);
    slow <= 1'b1;
    cfg.axis_channel_select <= 4'h3;
    fire();
    wait_req(n);
    fire();
    rd(hall_conv_pkg::ANGLE_OUTPUT_ADDR, a1);
    chk("held_angle", a0, a1);
    wait_done(600);
    n = 0;
    repeat (150) begin
      @(posedge mclk);
      #1 n += int'(conv_done === 1'b1);
    end
    chk("no_extra", 16'h0000, 16'(n));
    slow <= 1'b0;
  endtask : t_hold

  task automatic t_cont;
    @(posedge mclk);
    cfg.operating_mode <= hall_conv_pkg::MODE_CONTINUOUS;
    wait_done(400);
    chk("pipe_flag", 16'h0001, {15'h0, integrate_next});
    wait_done(400);
    @(posedge mclk);
    cfg.operating_mode <= hall_conv_pkg::MODE_TRIG_A;
    repeat (300) @(posedge mclk);
  endtask : t_cont

  initial begin
    #80000;
    err_count++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    cfg = 11'h031;
    trig_cmd = 1'b0;
    alert_pin = 1'b1;
    cs_n_pin = 1'b1;
    slow = 1'b0;
    rd_addr = 6'h00;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_pins();
    t_pseudo(hall_conv_pkg::CH_XZX, 2'h0, 16'h0002, hall_conv_pkg::PAIR_XZ, 16'h10e0);
    t_pseudo(hall_conv_pkg::CH_YZY, 2'h1, 16'h4002, hall_conv_pkg::PAIR_YZ, 16'h1289);
    t_hold();
    t_cont();
    print_verdict();
  end
endmodule : hall_conversion_angle_results_tb

`default_nettype wire
